// [rtl/sleep_ctrl_cfg.svh]
// offsets, field positions, reset values and timing counts of the sleep controller
`ifndef SLEEP_CTRL_CFG_SVH
`define SLEEP_CTRL_CFG_SVH

// register index on the plain register port
`define SLP_ADDR_CONTROL    4'h0
`define SLP_ADDR_STATUS     4'h1

// sleep_control fields
`define SLP_ARM_BIT         0
`define SLP_SEL_LSB         1
`define SLP_SEL_MSB         3
`define SLP_CONTROL_RESET   8'h00
`define SLP_STATUS_RESET    8'h00

// sleep_status fields
`define SLP_STAT_MODE_LSB   0
`define SLP_STAT_MODE_MSB   2
`define SLP_STAT_RESET_BIT  3
`define SLP_STAT_ASLEEP_BIT 4

// wake timing in core clock cycles
`define SLP_HOLD_CYC        4
`define SLP_STANDBY_CYC     6

`endif

// [rtl/sleep_ctrl_pkg.sv]
// types shared by the sleep controller
package sleep_ctrl_pkg;

    typedef enum logic [2:0] {
        MODE_IDLE    = 3'b000,
        MODE_ADC_NR  = 3'b001,
        MODE_PDOWN   = 3'b010,
        MODE_PSAVE   = 3'b011,
        MODE_STANDBY = 3'b110
    } sleep_mode_e;

    typedef enum logic [2:0] {
        ST_ACTIVE  = 3'b000,
        ST_ASLEEP  = 3'b001,
        ST_STARTUP = 3'b010,
        ST_HOLD    = 3'b011,
        ST_RESUME  = 3'b100
    } sleep_state_e;

    // pending, already enabled wake requests from the interrupt sources
    typedef struct packed {
        logic ext_a_level;
        logic ext_b_level;
        logic ext_edge;
        logic pin_change;
        logic twi_match;
        logic timer2_ovf;
        logic timer2_cmp;
        logic store_ready;
        logic adc_done;
        logic wdt_event;
        logic other_io;
    } wake_src_s;

    // clock domain and oscillator enables
    typedef struct packed {
        logic core_clock_domain;
        logic program_memory_clock_domain;
        logic peripheral_clock_domain;
        logic converter_clock_domain;
        logic async_clock_domain;
        logic main_osc;
        logic timer_osc;
        logic timer2_sync_clock;
    } clk_gate_s;

endpackage

// [rtl/sleep_ctrl.sv]
// sleep mode controller: arm, mode select, clock gating and wake sequencing
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctrl_cfg.svh"

// Notes on behaviour
// - sleep starts only if armed when halt executes; mode from sleep_select.
// - interrupt wake holds core four cycles past start-up, then resumes.
// - register file and static memory are never cleared by sleep.
// - any reset during sleep wakes to the reset vector.
// - select codes 000,001,010,011,110 name the five modes; others reserved.
// - control bits 7 to 4 always read zero.
// - idle stops core, program memory, timer 2 sync clocks and, unless timer 2 async, the timer oscillator.
// - idle wakes on every external and enabled internal interrupt.
// - entering idle or converter mode starts a conversion if enabled.
// - converter mode stops peripheral, core and program memory clocks.
// - converter mode wakes only on its listed sources and resets.
// - power-down stops oscillator and all generated clocks.
// - power-down wakes on reset, watchdog, address match, level, pin change.
// - power-down wake waits a start-up delay chosen by clock fuses.
// - power-save adds timer 2 wake when masked in and globally enabled.
// - power-save stops timer oscillator or clock source per timer 2 clock.
// - code 110 with crystal is standby: oscillator runs, six-cycle wake.
// - timer oscillator runs in idle/converter only when timer 2 async.
// - outside idle, external lines wake only through level interrupts.
module sleep_ctrl
    import sleep_ctrl_pkg::*;
#(
    parameter int CNT_W        = 16,
    parameter int STARTUP_CYC0 = 6,
    parameter int STARTUP_CYC1 = 16,
    parameter int STARTUP_CYC2 = 64,
    parameter int STARTUP_CYC3 = 256
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // register port
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // processor core
    input  wire logic       halt_exec_in,
    output logic            core_run_out,
    output logic            resume_irq_out,
    output logic            resume_reset_out,
    output logic            mem_retain_out,
    // wake sources, asynchronous while asleep
    input  wire wake_src_s  wake_src_in,
    input  wire logic       reset_req_in,
    // same-clock configuration
    input  wire logic       global_irq_en_in,
    input  wire logic [1:0] timer2_irq_mask_in,
    input  wire logic       timer2_async_in,
    input  wire logic       adc_enabled_in,
    input  wire logic       ext_crystal_in,
    input  wire logic [1:0] clock_select_fuses_in,
    // clock generators and converter
    output clk_gate_s       clk_gate_out,
    output logic            adc_start_out
);

    localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(`SLP_HOLD_CYC);
    localparam logic [CNT_W-1:0] STBY_CNT = CNT_W'(`SLP_STANDBY_CYC);

    sleep_state_e     state_q, state_d;
    sleep_mode_e      mode_q, mode_d, sel_mode;
    logic             arm_q;
    logic [2:0]       sel_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] delay;
    logic             by_reset_q;
    logic [7:0]       rdata_q;
    logic [2:0]       last_mode_q;
    logic             last_reset_q;
    wake_src_s        wake_s1_q, wake_s2_q;
    logic             rst_s1_q, rst_s2_q;
    logic             wake_hit;
    logic             deep_wake;
    logic             enter;
    clk_gate_s        gate_q, gate_d;
    logic             adc_start_q;
    logic             resume_irq_q, resume_rst_q;

    // two-stage sync: sources toggle while core clocks are stopped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_s1_q <= '0;
            wake_s2_q <= '0;
            rst_s1_q  <= 1'b0;
            rst_s2_q  <= 1'b0;
        end else begin
            wake_s1_q <= wake_src_in;
            wake_s2_q <= wake_s1_q;
            rst_s1_q  <= reset_req_in;
            rst_s2_q  <= rst_s1_q;
        end
    end

    // register writes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {sel_q, arm_q} <= 4'(`SLP_CONTROL_RESET);
        end else if (reg_wr_in && reg_addr_in == `SLP_ADDR_CONTROL) begin
            arm_q <= reg_wdata_in[`SLP_ARM_BIT];
            sel_q <= reg_wdata_in[`SLP_SEL_MSB:`SLP_SEL_LSB];
        end
    end

    // register reads, answered the cycle after the strobe
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `SLP_ADDR_CONTROL: rdata_q <= {4'h0, sel_q, arm_q};
                `SLP_ADDR_STATUS:  rdata_q <= {3'h0, state_q != ST_ACTIVE,
                                               last_reset_q, last_mode_q};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_q;

    // decode select field; reserved codes fall back to idle
    always_comb begin
        unique case (sel_q)
            3'b000:  sel_mode = MODE_IDLE;
            3'b001:  sel_mode = MODE_ADC_NR;
            3'b010:  sel_mode = MODE_PDOWN;
            3'b011:  sel_mode = MODE_PSAVE;
            3'b110:  sel_mode = ext_crystal_in ? MODE_STANDBY
                                               : MODE_PDOWN;
            default: sel_mode = MODE_IDLE;
        endcase
    end

    // sleep only when armed at the halt; unarmed halt is a no-op
    assign enter = state_q == ST_ACTIVE && halt_exec_in && arm_q;

    // outside idle the external lines wake only as levels
    assign deep_wake = wake_s2_q.wdt_event | wake_s2_q.twi_match
                     | wake_s2_q.ext_a_level | wake_s2_q.ext_b_level
                     | wake_s2_q.pin_change;

    // wake qualification per mode
    always_comb begin
        unique case (mode_q)
            MODE_IDLE:   wake_hit = |wake_s2_q;
            MODE_ADC_NR: wake_hit = deep_wake | wake_s2_q.adc_done
                         | wake_s2_q.timer2_ovf | wake_s2_q.timer2_cmp
                         | wake_s2_q.store_ready;
            MODE_PSAVE:  wake_hit = deep_wake | (global_irq_en_in
                         & |({wake_s2_q.timer2_cmp, wake_s2_q.timer2_ovf}
                             & timer2_irq_mask_in));
            default:     wake_hit = deep_wake;
        endcase
    end

    // start-up delay once a wake is seen
    always_comb begin
        delay = '0;
        unique case (mode_q)
            MODE_PDOWN, MODE_PSAVE: begin
                // fuse-selected oscillator restart time
                unique case (clock_select_fuses_in)
                    2'b00: delay = CNT_W'(STARTUP_CYC0);
                    2'b01: delay = CNT_W'(STARTUP_CYC1);
                    2'b10: delay = CNT_W'(STARTUP_CYC2);
                    2'b11: delay = CNT_W'(STARTUP_CYC3);
                endcase
            end
            MODE_STANDBY: delay = STBY_CNT;
            default:      delay = '0;
        endcase
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        unique case (state_q)
            ST_ACTIVE: begin
                if (enter) begin
                    state_d = ST_ASLEEP;
                    mode_d  = sel_mode;
                end
            end
            ST_ASLEEP: begin
                if (rst_s2_q || wake_hit) begin
                    state_d = (delay == '0) ? (rst_s2_q ? ST_RESUME : ST_HOLD)
                                            : ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (cnt_q == '0) begin
                    state_d = (by_reset_q || rst_s2_q) ? ST_RESUME : ST_HOLD;
                end
            end
            ST_HOLD: begin
                // a reset cuts the hold short
                if (rst_s2_q || cnt_q == '0) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: state_d = ST_ACTIVE;
            default:   state_d = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_ACTIVE;
            mode_q  <= MODE_IDLE;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
        end
    end

    // shared down counter for start-up and core hold
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= '0;
        end else if (state_d == ST_STARTUP && state_q != ST_STARTUP) begin
            cnt_q <= delay - CNT_W'(1);
        end else if (state_d == ST_HOLD && state_q != ST_HOLD) begin
            cnt_q <= HOLD_CNT - CNT_W'(1);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    // remember a reset wake so the core restarts at the reset vector
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            by_reset_q <= 1'b0;
        end else if (state_q == ST_ACTIVE) begin
            by_reset_q <= 1'b0;
        end else if (rst_s2_q) begin
            by_reset_q <= 1'b1;
        end
    end

    // status capture of the last sleep
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_mode_q  <= 3'h0;
            last_reset_q <= 1'b0;
        end else if (enter) begin
            last_mode_q  <= sel_mode;
            last_reset_q <= 1'b0;
        end else if (state_q == ST_RESUME) begin
            last_reset_q <= by_reset_q;
        end
    end

    // clock gates follow the next state so they line up with state_q
    always_comb begin
        gate_d = '1;
        if (state_d == ST_ASLEEP) begin
            gate_d.core_clock_domain           = 1'b0;
            gate_d.program_memory_clock_domain = 1'b0;
            gate_d.timer2_sync_clock           = 1'b0;
            unique case (mode_d)
                MODE_ADC_NR: begin
                    gate_d.peripheral_clock_domain = 1'b0;
                    gate_d.timer_osc = timer2_async_in;
                end
                MODE_PDOWN: gate_d = '0;
                MODE_PSAVE: begin
                    gate_d = '0;
                    gate_d.async_clock_domain = 1'b1;
                    // a sync timer 2 keeps the source but only for itself
                    gate_d.timer_osc         = timer2_async_in;
                    gate_d.main_osc          = !timer2_async_in;
                    gate_d.timer2_sync_clock = !timer2_async_in;
                end
                MODE_STANDBY: begin
                    gate_d = '0;
                    gate_d.main_osc = 1'b1;
                end
                default: gate_d.timer_osc = timer2_async_in;
            endcase
        end else if (state_d == ST_STARTUP || state_d == ST_HOLD) begin
            // core stays stopped until the resume cycle
            gate_d.core_clock_domain           = 1'b0;
            gate_d.program_memory_clock_domain = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_q <= '1;
        end else begin
            gate_q <= gate_d;
        end
    end

    // conversion kick and resume pulses
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adc_start_q  <= 1'b0;
            resume_irq_q <= 1'b0;
            resume_rst_q <= 1'b0;
        end else begin
            adc_start_q  <= enter && adc_enabled_in
                         && (sel_mode == MODE_IDLE || sel_mode == MODE_ADC_NR);
            resume_irq_q <= state_d == ST_RESUME && !(by_reset_q || rst_s2_q);
            resume_rst_q <= state_d == ST_RESUME && (by_reset_q || rst_s2_q);
        end
    end

    assign clk_gate_out     = gate_q;
    assign adc_start_out    = adc_start_q;
    assign resume_irq_out   = resume_irq_q;
    assign resume_reset_out = resume_rst_q;
    assign core_run_out     = state_q == ST_ACTIVE;
    // no clear path exists toward memories; retention only flags the freeze
    assign mem_retain_out   = state_q != ST_ACTIVE;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence hold_entry;
        state_q != ST_HOLD ##1 state_q == ST_HOLD && !by_reset_q;
    endsequence
    sequence standby_wake;
        state_q == ST_ASLEEP && mode_q == MODE_STANDBY && wake_hit
            && !rst_s2_q;
    endsequence

    chk_unarmed_halt_nop: assert property (
        state_q == ST_ACTIVE && halt_exec_in && !arm_q
        |=> state_q == ST_ACTIVE && gate_q.core_clock_domain)
        else $error("unarmed halt left active state");
    chk_armed_halt_sleeps: assert property (
        state_q == ST_ACTIVE && halt_exec_in && arm_q
        |=> state_q == ST_ASLEEP && !gate_q.core_clock_domain)
        else $error("armed halt did not enter sleep");
    chk_hold_four_cycles: assert property (
        hold_entry ##0 !rst_s2_q [*4]
        |-> state_q == ST_HOLD ##1 state_q == ST_RESUME && resume_irq_out)
        else $error("core hold not four cycles");
    chk_reset_wake_vector: assert property (
        state_q == ST_ASLEEP && rst_s2_q
        |-> ##[1:300] resume_reset_out)
        else $error("reset during sleep did not reach reset vector");
    chk_idle_gates: assert property (
        state_q == ST_ASLEEP && mode_q == MODE_IDLE
        |-> !gate_q.core_clock_domain && !gate_q.program_memory_clock_domain
            && gate_q.peripheral_clock_domain && gate_q.converter_clock_domain)
        else $error("idle gating wrong");
    chk_adc_nr_gates: assert property (
        state_q == ST_ASLEEP && mode_q == MODE_ADC_NR
        |-> !gate_q.peripheral_clock_domain && gate_q.converter_clock_domain
            && gate_q.main_osc)
        else $error("converter mode gating wrong");
    chk_pdown_gates: assert property (
        state_q == ST_ASLEEP && mode_q == MODE_PDOWN |-> gate_q == '0)
        else $error("power-down left a clock running");
    chk_standby_six: assert property (
        standby_wake
        |=> state_q == ST_STARTUP [*6]
            ##1 state_q inside {ST_HOLD, ST_RESUME})
        else $error("standby wake not six cycles");
    chk_reserved_idle: assert property (
        enter && sel_q[2] && sel_q != 3'b110 |=> mode_q == MODE_IDLE)
        else $error("reserved code not treated as idle");
    chk_control_upper_zero: assert property (
        reg_rd_in && reg_addr_in == `SLP_ADDR_CONTROL
        |=> reg_rdata_out[7:4] == 4'h0
            && reg_rdata_out[0] == $past(arm_q))
        else $error("control read upper bits not zero");
    chk_edge_only_idle: assert property (
        state_q == ST_ASLEEP && mode_q != MODE_IDLE && !rst_s2_q
        && wake_s2_q.ext_edge && (11'(wake_s2_q) & 11'h6fe) == 11'h000
        |=> state_q == ST_ASLEEP)
        else $error("edge interrupt woke a deep mode");
    chk_conversion_kick: assert property (
        enter && adc_enabled_in && sel_q == 3'b001
        |=> adc_start_out ##1 !adc_start_out)
        else $error("conversion not started on entry");

endmodule
`default_nettype wire

// [tb/wake_source_model.sv]
// far-side model of the interrupt sources feeding the sleep controller
`timescale 1ns/100ps
`default_nettype none
module wake_source_model
    import sleep_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic      clk_in,
    input  wire logic      nrst_in,
    // requests from the bench
    input  wire wake_src_s set_in,
    input  wire logic      clr_in,
    // core has been resumed
    input  wire logic      ack_in,
    // lines to the controller
    output var  wake_src_s wake_src_out
);
    // a source keeps its level until the core is resumed or the bench
    // withdraws it; a short pulse could be lost in the deep modes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_src_out <= '0;
        end else if (clr_in || ack_in) begin
            wake_src_out <= '0;
        end else begin
            wake_src_out <= wake_src_out | set_in;
        end
    end
endmodule
`default_nettype wire

// [tb/sleep_mode_controller_test.sv]
// bench of the sleep controller: registers, mode gating and wake paths
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_controller_test;
    import sleep_ctrl_pkg::*;
    localparam logic [2:0]  CODE [9] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3,
        3'h6, 3'h4, 3'h5, 3'h7};
    localparam logic [1:0]  FUSE [9] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h1,
        2'h0, 2'h0, 2'h0, 2'h0};
    localparam logic [7:0]  GATE [9] = '{8'h3c, 8'h1c, 8'h00, 8'h00,
        8'h0a, 8'h04, 8'h3c, 8'h3c, 8'h3c};
    localparam logic [10:0] SRC [9] = '{11'h001, 11'h004, 11'h400,
        11'h080, 11'h010, 11'h080, 11'h002, 11'h001, 11'h100};
    // extra start-up cycles over idle
    localparam int          DLY [9] = '{0, 0, 2, 5, 3, 6, 0, 0, 0};
    // sources that each mode must ignore
    localparam logic [2:0]  RCODE [4] = '{3'h2, 3'h1, 3'h3, 3'h6};
    localparam logic [10:0] RSRC [4] = '{11'h10d, 11'h101, 11'h030,
        11'h020};

    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  rdata;
    logic        halt_s = 1'b0;
    logic        run, res_irq, res_rst, retain, adc_start;
    wake_src_s   wake, set_src = '0;
    logic        clr_src = 1'b0;
    logic        rst_req = 1'b0;
    logic        glob_en = 1'b1;
    logic        t2_async = 1'b0;
    logic [1:0]  fuses = 2'h0;
    logic [1:0]  mask = 2'h2;
    logic        adc_en = 1'b1;
    logic        xtal = 1'b1;
    clk_gate_s   gate;
    int          n_mismatch = 0;
    int          checks = 0;
    int          base, lat, i;
    logic        byr;
    logic [7:0]  rd;

    always #2.5 clk_in = ~clk_in;

    sleep_ctrl #(
        .STARTUP_CYC0 (2),
        .STARTUP_CYC1 (3),
        .STARTUP_CYC2 (4),
        .STARTUP_CYC3 (5)
    ) u_sleep_ctrl (
        .clk_in(clk_in), .nrst_in(nrst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .halt_exec_in(halt_s), .core_run_out(run),
        .resume_irq_out(res_irq), .resume_reset_out(res_rst),
        .mem_retain_out(retain), .wake_src_in(wake),
        .reset_req_in(rst_req), .global_irq_en_in(glob_en),
        .timer2_irq_mask_in(mask), .timer2_async_in(t2_async),
        .adc_enabled_in(adc_en), .ext_crystal_in(xtal),
        .clock_select_fuses_in(fuses), .clk_gate_out(gate),
        .adc_start_out(adc_start)
    );

    wake_source_model u_wake_source_model (
        .clk_in(clk_in), .nrst_in(nrst_in), .set_in(set_src),
        .clr_in(clr_src), .ack_in(res_irq | res_rst),
        .wake_src_out(wake)
    );

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic halt();
        @(posedge clk_in);
        halt_s <= 1'b1;
        @(posedge clk_in);
        halt_s <= 1'b0;
        #1;
    endtask

    task automatic pulse(input logic [10:0] s);
        @(posedge clk_in);
        set_src <= s;
        @(posedge clk_in);
        set_src <= '0;
    endtask

    // bounded wait, a hang ends the run as a failure
    task automatic wait_resume(output int n, output logic by_rst);
        n = 0;
        while (res_irq !== 1'b1 && res_rst !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > 400) begin
                n_mismatch++;
                close_out();
            end
        end
        by_rst = res_rst;
    endtask

    initial begin
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk("gate_reset", {run, gate}, 9'h1ff);
        rdreg(4'h0, rd);
        chk("ctrl_reset", rd, 8'h00);
        wr(4'h0, 8'hff);
        rdreg(4'h0, rd);
        chk("ctrl_unused", rd, 8'h0f);
        wr(4'h1, 8'hff);
        wr(4'hf, 8'hff);
        rdreg(4'h1, rd);
        chk("status_ro", rd, 8'h00);
        rdreg(4'hf, rd);
        chk("unmapped", rd, 8'h00);
        wr(4'h0, 8'h04);
        halt();
        chk("noop", {run, gate[7:6], adc_start}, 4'hE);
        for (i = 0; i < 9; i++) begin
            t2_async <= (CODE[i] == 3'h3);
            fuses <= FUSE[i];
            wr(4'h0, {4'h0, CODE[i], 1'b1});
            halt();
            chk("asleep", run, 1'b0);
            chk("gate_hi", gate[7:5], GATE[i][7:5]);
            chk("gate_lo", gate[4:0], GATE[i][4:0]);
            chk("adc_start", adc_start,
                CODE[i][1] == 1'b0 || CODE[i] == 3'h7);
            chk("retain", retain, 1'b1);
            pulse(SRC[i]);
            wait_resume(lat, byr);
            chk("irq_path", byr, 1'b0);
            if (i == 0) begin
                base = lat;
            end
            chk("hold", lat >= 6, 1'b1);
            if (DLY[i] >= 0) begin
                chk("delay", lat - base, DLY[i]);
            end
            wr(4'h0, 8'h00);
            rdreg(4'h1, rd);
            chk("running", {run, gate[7:6]}, 3'h7);
            chk("status", rd, (CODE[i][2] && CODE[i] != 3'h6) ? 8'h00
                : {5'h00, CODE[i]});
        end
        // converter off and no crystal: 110 falls back to power-down
        adc_en <= 1'b0;
        xtal <= 1'b0;
        for (i = 0; i < 4; i++) begin
            t2_async <= (RCODE[i] == 3'h3);
            glob_en <= (RCODE[i] != 3'h3);
            wr(4'h0, {4'h0, RCODE[i], 1'b1});
            halt();
            chk("adc_off", adc_start, 1'b0);
            chk("osc", gate[2], RCODE[i] == 3'h1);
            pulse(RSRC[i]);
            repeat (30) @(posedge clk_in);
            #1;
            chk("refused", run, 1'b0);
            @(posedge clk_in);
            clr_src <= 1'b1;
            rst_req <= 1'b1;
            @(posedge clk_in);
            clr_src <= 1'b0;
            wait_resume(lat, byr);
            @(posedge clk_in);
            rst_req <= 1'b0;
            chk("reset_path", byr, 1'b1);
            rdreg(4'h1, rd);
            chk("reset_flag", rd[3], 1'b1);
            wr(4'h0, 8'h00);
        end
        close_out();
    end
endmodule
`default_nettype wire
